// ===== sim_pkg.sv
package sim_pkg;

  // bus geometry
  localparam int ADR_W = 8;
  localparam int IDX_W = 6;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int REG_W = 8;
  localparam int SYNC_W = 29;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BC_STATUS = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_SW_STATUS = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_COMMON_MASK = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_CONFIG_CHANNEL_EVENT_MASK = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CHARGER_DETECT_EVENT_MASK = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_SW_MASK = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h15;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_EVT_CLEAR = 6'h21;

  // reset values and implemented bits
  localparam logic [REG_W-1:0] COMMON_MASK_RST = 8'h04;
  localparam logic [REG_W-1:0] CONFIG_CHANNEL_EVENT_MASK_RST = 8'h00;
  localparam logic [REG_W-1:0] CHARGER_DETECT_EVENT_MASK_RST = 8'h00;
  localparam logic [REG_W-1:0] SW_MASK_RST = 8'h00;
  localparam logic [REG_W-1:0] CONFIG_CHANNEL_EVENT_MASK_BITS = 8'h3F;
  localparam logic [REG_W-1:0] CHARGER_DETECT_EVENT_MASK_BITS = 8'h1F;
  localparam logic [REG_W-1:0] SW_MASK_BITS = 8'h03;
  localparam logic IRQ_PIN_EN_RST = 1'b1;

  // read-only status fields and the writable control pin-enable bit
  localparam int SW_READY_BIT = 7;
  localparam int SW_CLOSED_BIT = 1;
  localparam int SW_SUPPLY_OVERVOLTAGE_BIT = 0;
  localparam int BC_RUN_BIT = 1;
  localparam int BC_TMO_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 7;

  // event and mask positions inside each group
  localparam int CM_THERMAL = 4;
  localparam int CM_LOWPWR = 3;
  localparam int CC_STATE = 5;
  localparam int CC_PIN = 4;
  localparam int CC_CUR = 3;
  localparam int CC_VCN = 2;
  localparam int CC_OCP = 1;
  localparam int CC_ABORT = 0;
  localparam int BC_TYPE = 4;
  localparam int BC_PROP = 3;
  localparam int BC_RISE = 2;
  localparam int BC_FALL = 1;
  localparam int BC_TMO = 0;
  localparam int SWM_CLOSED = 1;
  localparam int SWM_SUPPLY_OVERVOLTAGE = 0;

  // group lanes in the event status word
  localparam int EVT_CMN_LSB = 0;
  localparam int EVT_CC_LSB = 8;
  localparam int EVT_BC_LSB = 16;
  localparam int EVT_SW_LSB = 24;

  // positions in the synchronised input vector
  localparam int RAW_CMN_LSB = 0;
  localparam int RAW_CC_STATE = 8;
  localparam int RAW_CC_PIN = 11;
  localparam int RAW_CC_CUR = 13;
  localparam int RAW_CC_VCN = 15;
  localparam int RAW_CC_OCP = 16;
  localparam int RAW_CC_ABORT = 17;
  localparam int RAW_BC_TYPE = 18;
  localparam int RAW_BC_PROP = 20;
  localparam int RAW_BC_RUN = 23;
  localparam int RAW_BC_TMO = 24;
  localparam int RAW_SW_SUPPLY_OVERVOLTAGE = 25;
  localparam int RAW_SW_CLOSED = 26;
  localparam int RAW_READY = 27;
  localparam int RAW_AUTO = 28;

  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK = 2'b10
  } sim_wb_state_t;

endpackage

// ===== sim_reg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sim_reg_if;
  import sim_pkg::*;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic [SEL_W-1:0] sel;
  logic [DAT_W-1:0] wdata;
  logic [DAT_W-1:0] rdata;
  modport bus (output wr, output idx, output sel, output wdata, input rdata);
  modport regs (input wr, input idx, input sel, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== sim_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sim_sync import sim_pkg::*; #(
  parameter int W = SYNC_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels from outside the clock domain
  input wire logic [W-1:0] asyncIn,
  // synchronised view and edges
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage1_next;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage2_next;
  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;

  always_comb begin
    stage1_next = asyncIn;
    stage2_next = stage1_reg;
    prev_next = stage2_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      prev_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
      prev_reg <= prev_next;
    end
  end

  assign level = stage2_reg;
  assign rise = stage2_reg & ~prev_reg;
  assign fall = prev_reg & ~stage2_reg;
endmodule
`default_nettype wire

// ===== sim_wb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module sim_wb_slave import sim_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // register file side
  sim_reg_if.bus rif
);
  sim_wb_state_t state_reg;
  sim_wb_state_t state_next;
  logic [DAT_W-1:0] dat_reg;
  logic [DAT_W-1:0] dat_next;
  logic req;

  assign req = wb_cyc_i && wb_stb_i;

  always_comb begin
    state_next = state_reg;
    dat_next = dat_reg;
    unique case (state_reg)
      WB_IDLE: begin
        if (req) begin
          state_next = WB_ACK;
          dat_next = rif.rdata;
        end
      end
      WB_ACK: begin
        state_next = WB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= WB_IDLE;
      dat_reg <= '0;
    end else begin
      state_reg <= state_next;
      dat_reg <= dat_next;
    end
  end

  // write commits on the edge where the master sees ack
  assign wb_ack_o = (state_reg == WB_ACK);
  assign wb_dat_o = dat_reg;
  assign rif.wr = req && wb_we_i && (state_reg == WB_ACK);
  assign rif.idx = wb_adr_i[ADR_W-1:2];
  assign rif.sel = wb_sel_i;
  assign rif.wdata = wb_dat_i;

  a_ack_single: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (@(posedge clk) disable iff (!rst_n)
    (req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");
endmodule
`default_nettype wire

// ===== status_interrupt_masks.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// (R1) contact timeout flag reads the live synchronised level, 0 again once the input drops
// (R2) ready bit reads 0 until settings loaded
// (R3) switch bit reads 1 only when closed
// (R4) overvoltage bit follows detector; register read-only
// (R5) mask bit 0 masks, 1 unmasks
// (R6) common mask bit layout fault to valid
// (R7) common mask resets 0x04, wake unmasked
// (R8) low-power event is a status change
// (R9) config-channel mask layout, resets to zero
// (R10) charger mask layout, resets to zero
// (R11) falling run edge has own mask
// (R12) switch mask bits 1:0, rest reserved
// (R13) pin is interrupt only when enabled
// (R14) pending flags gated by masks drive interrupt
// (R15) read-only and reserved bits ignore writes
module status_interrupt_masks import sim_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // common supply and thermal status
  input wire logic [REG_W-1:0] commonStatus,
  // configuration channel status
  input wire logic [2:0] ccState,
  input wire logic [1:0] ccActivePin,
  input wire logic [1:0] ccCurrent,
  input wire logic connPowerStatus,
  input wire logic connPowerOvercurrent,
  input wire logic detectAbort,
  // charger detection status
  input wire logic [1:0] chargerType,
  input wire logic [2:0] proprietaryType,
  input wire logic detectRun,
  input wire logic contactDetectTimeout,
  // supply switch and loader status
  input wire logic supplySwitchClosed,
  input wire logic supplyOvervoltage,
  input wire logic otpLoadDone,
  input wire logic autoConfigFlag,
  // interrupt outputs
  output logic irq,
  output logic irqPin_n
);

  ////////////////////////////////////////////////////////////////////////////
  // bus front end and input synchronisers

  sim_reg_if rif ();

  sim_wb_slave u_wb (
    .clk(clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rif(rif)
  );

  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] lvl;
  logic [SYNC_W-1:0] rise;
  logic [SYNC_W-1:0] fall;
  logic [SYNC_W-1:0] chg;

  assign rawIn = {autoConfigFlag, otpLoadDone, supplySwitchClosed, supplyOvervoltage,
                  contactDetectTimeout, detectRun, proprietaryType, chargerType,
                  detectAbort, connPowerOvercurrent, connPowerStatus, ccCurrent,
                  ccActivePin, ccState, commonStatus};

  sim_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(rawIn),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign chg = rise | fall;

  ////////////////////////////////////////////////////////////////////////////
  // event sources

  logic [DAT_W-1:0] evt;

  always_comb begin
    evt = '0;
    // every common bit raises on change, so low power is a change event
    evt[EVT_CMN_LSB +: REG_W] = chg[RAW_CMN_LSB +: REG_W]; // [R8]
    evt[EVT_CC_LSB + CC_STATE] = |chg[RAW_CC_STATE +: 3];
    evt[EVT_CC_LSB + CC_PIN] = |chg[RAW_CC_PIN +: 2];
    evt[EVT_CC_LSB + CC_CUR] = |chg[RAW_CC_CUR +: 2];
    evt[EVT_CC_LSB + CC_VCN] = chg[RAW_CC_VCN];
    evt[EVT_CC_LSB + CC_OCP] = chg[RAW_CC_OCP];
    evt[EVT_CC_LSB + CC_ABORT] = chg[RAW_CC_ABORT];
    evt[EVT_BC_LSB + BC_TYPE] = |chg[RAW_BC_TYPE +: 2];
    evt[EVT_BC_LSB + BC_PROP] = |chg[RAW_BC_PROP +: 3];
    evt[EVT_BC_LSB + BC_RISE] = rise[RAW_BC_RUN]; // [R10]
    evt[EVT_BC_LSB + BC_FALL] = fall[RAW_BC_RUN]; // [R11]
    evt[EVT_BC_LSB + BC_TMO] = rise[RAW_BC_TMO];
    evt[EVT_SW_LSB + SWM_CLOSED] = chg[RAW_SW_CLOSED];
    evt[EVT_SW_LSB + SWM_SUPPLY_OVERVOLTAGE] = chg[RAW_SW_SUPPLY_OVERVOLTAGE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [REG_W-1:0] commonMask_reg;
  logic [REG_W-1:0] commonMask_next;
  logic [REG_W-1:0] ccMask_reg;
  logic [REG_W-1:0] ccMask_next;
  logic [REG_W-1:0] bcMask_reg;
  logic [REG_W-1:0] bcMask_next;
  logic [REG_W-1:0] swMask_reg;
  logic [REG_W-1:0] swMask_next;
  logic irqPinEn_reg;
  logic irqPinEn_next;
  logic ready_reg;
  logic ready_next;
  logic [DAT_W-1:0] pending_reg;
  logic [DAT_W-1:0] pending_next;
  logic [DAT_W-1:0] clearVec;
  logic [DAT_W-1:0] enableVec;
  logic wrLow;

  assign wrLow = rif.wr && rif.sel[0];
  assign enableVec = {swMask_reg, bcMask_reg, ccMask_reg, commonMask_reg};

  genvar g;
  generate
    for (g = 0; g < SEL_W; g++) begin : g_clear
      assign clearVec[g*REG_W +: REG_W] =
        (rif.wr && rif.idx == IDX_EVT_CLEAR && rif.sel[g]) ?
        rif.wdata[g*REG_W +: REG_W] : '0;
    end
  endgenerate

  always_comb begin
    commonMask_next = commonMask_reg;
    ccMask_next = ccMask_reg;
    bcMask_next = bcMask_reg;
    swMask_next = swMask_reg;
    irqPinEn_next = irqPinEn_reg;
    // loader completion latches until the next reset
    ready_next = ready_reg | lvl[RAW_READY]; // [R2]
    // a new event beats a clear in the same cycle
    pending_next = (pending_reg & ~clearVec) | evt; // [R14]
    if (wrLow) begin
      unique case (rif.idx)
        IDX_COMMON_MASK: commonMask_next = rif.wdata[REG_W-1:0]; // [R5] [R6]
        IDX_CONFIG_CHANNEL_EVENT_MASK: ccMask_next = rif.wdata[REG_W-1:0] & CONFIG_CHANNEL_EVENT_MASK_BITS; // [R9] [R15]
        IDX_CHARGER_DETECT_EVENT_MASK: bcMask_next = rif.wdata[REG_W-1:0] & CHARGER_DETECT_EVENT_MASK_BITS; // [R10] [R15]
        IDX_SW_MASK: swMask_next = rif.wdata[REG_W-1:0] & SW_MASK_BITS; // [R12] [R15]
        IDX_CTRL: irqPinEn_next = rif.wdata[CTRL_IRQ_EN_BIT];
        default: begin
          // status and unmapped indices take no write
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      commonMask_reg <= COMMON_MASK_RST; // [R7]
      ccMask_reg <= CONFIG_CHANNEL_EVENT_MASK_RST; // [R9]
      bcMask_reg <= CHARGER_DETECT_EVENT_MASK_RST; // [R10]
      swMask_reg <= SW_MASK_RST; // [R12]
      irqPinEn_reg <= IRQ_PIN_EN_RST;
      ready_reg <= 1'b0;
      pending_reg <= '0;
    end else begin
      commonMask_reg <= commonMask_next;
      ccMask_reg <= ccMask_next;
      bcMask_reg <= bcMask_next;
      swMask_reg <= swMask_next;
      irqPinEn_reg <= irqPinEn_next;
      ready_reg <= ready_next;
      pending_reg <= pending_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rif.rdata = '0;
    unique case (rif.idx)
      IDX_BC_STATUS: begin
        rif.rdata[BC_RUN_BIT] = lvl[RAW_BC_RUN];
        rif.rdata[BC_TMO_BIT] = lvl[RAW_BC_TMO]; // [R1]
      end
      IDX_SW_STATUS: begin
        rif.rdata[SW_READY_BIT] = ready_reg; // [R2]
        rif.rdata[SW_CLOSED_BIT] = lvl[RAW_SW_CLOSED]; // [R3]
        rif.rdata[SW_SUPPLY_OVERVOLTAGE_BIT] = lvl[RAW_SW_SUPPLY_OVERVOLTAGE]; // [R4]
      end
      IDX_COMMON_MASK: rif.rdata[REG_W-1:0] = commonMask_reg;
      IDX_CONFIG_CHANNEL_EVENT_MASK: rif.rdata[REG_W-1:0] = ccMask_reg;
      IDX_CHARGER_DETECT_EVENT_MASK: rif.rdata[REG_W-1:0] = bcMask_reg;
      IDX_SW_MASK: rif.rdata[REG_W-1:0] = swMask_reg;
      IDX_CTRL: rif.rdata[CTRL_IRQ_EN_BIT] = irqPinEn_reg;
      IDX_EVT_STATUS: rif.rdata = pending_reg;
      default: rif.rdata = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt outputs

  logic irq_reg;
  logic irq_next;
  logic pin_reg;
  logic pin_next;
  logic flagLevel;

  // with the pin in flag mode it shows thermal, overvoltage or autoconfig
  assign flagLevel = lvl[RAW_CMN_LSB + CM_THERMAL] | lvl[RAW_SW_SUPPLY_OVERVOLTAGE] | lvl[RAW_AUTO];

  always_comb begin
    irq_next = |(pending_reg & enableVec); // [R5] [R14]
    pin_next = irqPinEn_reg ? ~irq_reg : ~flagLevel; // [R13]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
      pin_reg <= 1'b1;
    end else begin
      irq_reg <= irq_next;
      pin_reg <= pin_next;
    end
  end

  assign irq = irq_reg;
  assign irqPin_n = pin_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_mask_write(logic [IDX_W-1:0] i);
    wrLow && rif.idx == i;
  endsequence

  sequence s_quiet_two;
    ((pending_reg & enableVec) == '0) [*2];
  endsequence

  a_common_reset: assert property ($rose(rst_n) |-> commonMask_reg == COMMON_MASK_RST) // [R7]
    else $error("common mask reset value wrong");
  a_common_write: assert property (s_mask_write(IDX_COMMON_MASK)
    |=> commonMask_reg == $past(rif.wdata[REG_W-1:0])) // [R6]
    else $error("common mask write lost");
  a_cc_write: assert property (s_mask_write(IDX_CONFIG_CHANNEL_EVENT_MASK)
    |=> ccMask_reg == ($past(rif.wdata[REG_W-1:0]) & CONFIG_CHANNEL_EVENT_MASK_BITS)) // [R9]
    else $error("config channel mask write wrong");
  a_reserved_zero: assert property (swMask_reg[REG_W-1:2] == '0 // [R12]
    && (ccMask_reg & ~CONFIG_CHANNEL_EVENT_MASK_BITS) == '0 && (bcMask_reg & ~CHARGER_DETECT_EVENT_MASK_BITS) == '0)
    else $error("reserved mask bit set");
  a_pending_sticky: assert property ((|evt) |=> (pending_reg & $past(evt)) == $past(evt)) // [R14]
    else $error("event lost against clear");
  a_unmask_fires: assert property ((|(pending_reg & enableVec)) |=> irq) // [R5]
    else $error("unmasked pending did not interrupt");
  a_masked_quiet: assert property (s_quiet_two |-> !irq) // [R14]
    else $error("interrupt with nothing enabled");
  a_ready_sticky: assert property (rif.rdata[SW_READY_BIT] && rif.idx == IDX_SW_STATUS // [R2]
    |=> ready_reg)
    else $error("ready bit dropped");
  a_ready_cause: assert property ($rose(ready_reg) |-> $past(lvl[RAW_READY])) // [R2]
    else $error("ready set before load done");
  a_switch_read: assert property (rif.idx == IDX_SW_STATUS // [R3]
    |-> rif.rdata[SW_CLOSED_BIT] == lvl[RAW_SW_CLOSED] && rif.rdata[SW_SUPPLY_OVERVOLTAGE_BIT] ==
    lvl[RAW_SW_SUPPLY_OVERVOLTAGE])
    else $error("switch status read wrong");
  a_timeout_read: assert property (rif.idx == IDX_BC_STATUS // [R1]
    |-> rif.rdata[BC_TMO_BIT] == lvl[RAW_BC_TMO])
    else $error("timeout flag read wrong");
  a_lowpwr_change: assert property ($changed(lvl[RAW_CMN_LSB + CM_LOWPWR]) // [R8]
    |=> pending_reg[EVT_CMN_LSB + CM_LOWPWR])
    else $error("low power change not recorded");
  a_run_fall: assert property ($fell(lvl[RAW_BC_RUN]) // [R11]
    |=> pending_reg[EVT_BC_LSB + BC_FALL] && $past(!evt[EVT_BC_LSB + BC_RISE]))
    else $error("falling run event missing");
  a_pin_mode: assert property (irqPinEn_reg && irq |=> !irqPin_n) // [R13]
    else $error("pin not showing interrupt");
endmodule
`default_nettype wire

// ===== status_interrupt_masks_test.sv
`timescale 1ns/100ps
`default_nettype none
module status_interrupt_masks_test import sim_pkg::*;;
  logic clk;
  logic rstN;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [ADR_W-1:0] wbAdr;
  logic [SEL_W-1:0] wbSel;
  logic [DAT_W-1:0] wbDatI;
  logic [DAT_W-1:0] wbDatO;
  logic wbAck;
  logic [REG_W-1:0] commonStatus;
  logic [2:0] ccState;
  logic [1:0] ccActivePin;
  logic [1:0] ccCurrent;
  logic connPowerStatus;
  logic connPowerOvercurrent;
  logic detectAbort;
  logic [1:0] chargerType;
  logic [2:0] proprietaryType;
  logic detectRun;
  logic contactDetectTimeout;
  logic supplySwitchClosed;
  logic supplyOvervoltage;
  logic otpLoadDone;
  logic autoConfigFlag;
  logic irq;
  logic irqPin_n;
  logic [DAT_W-1:0] expQ[$];
  int errCount = 0;
  int nChecks = 0;

  status_interrupt_masks dut_u (
    .clk(clk), .rst_n(rstN),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .commonStatus(commonStatus), .ccState(ccState), .ccActivePin(ccActivePin),
    .ccCurrent(ccCurrent), .connPowerStatus(connPowerStatus),
    .connPowerOvercurrent(connPowerOvercurrent), .detectAbort(detectAbort),
    .chargerType(chargerType), .proprietaryType(proprietaryType), .detectRun(detectRun),
    .contactDetectTimeout(contactDetectTimeout), .supplySwitchClosed(supplySwitchClosed),
    .supplyOvervoltage(supplyOvervoltage), .otpLoadDone(otpLoadDone),
    .autoConfigFlag(autoConfigFlag), .irq(irq), .irqPin_n(irqPin_n)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bad(input string msg);
    errCount++;
    $display("BAD t=%0t %s", $time, msg);
  endtask

  task automatic end_of_test();
    if (errCount == 0 && nChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmpBit(input logic got, input logic exp, input string what);
    nChecks++;
    if (got !== exp) bad(what);
  endtask

  task automatic cmpWord(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
    nChecks++;
    if (got !== exp) bad($sformatf("read %h expected %h", got, exp));
  endtask

  // classic single cycle, held until ack is sampled
  task automatic wbCycle(input logic we, input logic [ADR_W-1:0] adr,
                         input logic [DAT_W-1:0] dat);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1) begin
      bad("no ack");
      end_of_test();
    end else begin
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
    end
  endtask

  task automatic wr(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] dat);
    wbCycle(1'b1, adr, dat);
  endtask

  task automatic rd(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] exp);
    expQ.push_back(exp);
    wbCycle(1'b0, adr, 32'h0);
  endtask

  // byte lanes of m go to the four mask registers
  task automatic setMasks(input logic [31:0] m);
    for (int i = 0; i < 4; i++) begin
      wr(8'h30 + 8'(4 * i), {24'h0, m[8*i +: 8]});
    end
  endtask

  // flip one event source; pending position follows evtBit
  task automatic poke(input int n);
    @(posedge clk);
    case (n)
      8: ccState <= ccState ^ 3'h1;
      9: ccActivePin <= ccActivePin ^ 2'h1;
      10: ccCurrent <= ccCurrent ^ 2'h1;
      11: connPowerStatus <= ~connPowerStatus;
      12: connPowerOvercurrent <= ~connPowerOvercurrent;
      13: detectAbort <= ~detectAbort;
      14: chargerType <= chargerType ^ 2'h2;
      15: proprietaryType <= proprietaryType ^ 3'h4;
      16: detectRun <= 1'b1;
      17: detectRun <= 1'b0;
      18: contactDetectTimeout <= 1'b1;
      19: supplySwitchClosed <= ~supplySwitchClosed;
      20: supplyOvervoltage <= ~supplyOvervoltage;
      default: commonStatus[n] <= ~commonStatus[n];
    endcase
  endtask

  function automatic int evtBit(input int n);
    if (n < 8) return n;
    if (n < 14) return 21 - n;
    if (n < 19) return 34 - n;
    return 44 - n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      if (expQ.size() == 0) bad("unexpected read data");
      else cmpWord(wbDatO, expQ.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] implBits[4];
    logic [31:0] r;
    int b;
    implBits = '{8'hFF, 8'h3F, 8'h1F, 8'h03};
    {rstN, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = '0;
    {commonStatus, ccState, ccActivePin, ccCurrent, connPowerStatus} = '0;
    {connPowerOvercurrent, detectAbort, chargerType, proprietaryType, detectRun} = '0;
    {contactDetectTimeout, supplySwitchClosed, supplyOvervoltage} = '0;
    {otpLoadDone, autoConfigFlag} = '0;
    void'($urandom(32'h4C8E));
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    rd(8'h30, 32'h04);
    rd(8'h34, 32'h00);
    rd(8'h38, 32'h00);
    rd(8'h3C, 32'h00);
    rd(8'h54, 32'h80);
    rd(8'h2C, 32'h00);
    rd(8'h80, 32'h00);
    cmpBit(irq, 1'b0, "irq after reset");
    cmpBit(irqPin_n, 1'b1, "pin after reset");
    // mask readback, reserved bits read zero
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) begin
        r = (k == 1) ? 32'hFFFFFFFF : ((k == 2) ? 32'h0 : $urandom());
        wr(8'h30 + 8'(4 * i), r);
        rd(8'h30 + 8'(4 * i), {24'h0, r[7:0] & implBits[i]});
      end
    end
    // pin in flag mode
    wr(8'h54, 32'h0);
    rd(8'h54, 32'h0);
    @(posedge clk);
    autoConfigFlag <= 1'b1;
    repeat (6) @(posedge clk);
    cmpBit(irqPin_n, 1'b0, "flag mode pin");
    autoConfigFlag <= 1'b0;
    repeat (6) @(posedge clk);
    cmpBit(irqPin_n, 1'b1, "flag mode pin idle");
    wr(8'h54, 32'h80);
    // switch and charger status
    @(posedge clk);
    supplySwitchClosed <= 1'b1;
    supplyOvervoltage <= 1'b1;
    otpLoadDone <= 1'b1;
    contactDetectTimeout <= 1'b1;
    detectRun <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h2C, 32'h83);
    rd(8'h28, 32'h03);
    wr(8'h2C, 32'hFFFFFFFF);
    rd(8'h2C, 32'h83);
    @(posedge clk);
    otpLoadDone <= 1'b0;
    supplySwitchClosed <= 1'b0;
    contactDetectTimeout <= 1'b0;
    detectRun <= 1'b0;
    repeat (6) @(posedge clk);
    rd(8'h2C, 32'h81);
    rd(8'h28, 32'h00);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h00);
    // every event source: masked, unmasked, cleared
    for (int n = 0; n < 21; n++) begin
      b = evtBit(n);
      wr(8'h84, 32'hFFFFFFFF);
      setMasks(~(32'h1 << b));
      poke(n);
      repeat (6) @(posedge clk);
      rd(8'h80, 32'h1 << b);
      cmpBit(irq, 1'b0, "irq while masked");
      setMasks(32'h1 << b);
      repeat (3) @(posedge clk);
      cmpBit(irq, 1'b1, "irq unmasked");
      cmpBit(irqPin_n, 1'b0, "pin unmasked");
      wr(8'h84, 32'h1 << b);
      repeat (4) @(posedge clk);
      cmpBit(irq, 1'b0, "irq after clear");
      rd(8'h80, 32'h0);
    end
    // second reset in mid-run
    @(posedge clk);
    rstN <= 1'b0;
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    rd(8'h30, 32'h04);
    rd(8'h3C, 32'h00);
    repeat (2) @(posedge clk);
    if (expQ.size() != 0) bad("reads left unanswered");
    end_of_test();
  end
endmodule
`default_nettype wire
